// *** testbench/sfc_channel_chk.sv ***
`timescale 1ns/1ps
`include "sfc_map.svh"
module sfc_channel_chk #(
  parameter int DEPTH = 96,
  parameter int DIV_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire sfc_pkg::sfc_addr_t addr,
  input wire sfc_pkg::sfc_word_t wdata,
  input wire logic wr,
  input wire logic rd,
  input wire sfc_pkg::sfc_word_t rdata,
  input wire logic txd_in,
  input wire logic rts_in,
  input wire logic dtr_in,
  input wire logic rxd_out,
  input wire logic cts_out,
  input wire logic dsr_out
);
  import sfc_pkg::*;
  sfc_word_t div_seen;
  logic [4:0] mode_seen;
  // shadow of accepted settings
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_seen <= sfc_word_t'(`SFC_DIV_RESET);
      mode_seen <= `SFC_MODE_RESET;
    end else if (wr && addr == `SFC_ADDR_DIV && wdata >= 16'h0002) begin
      div_seen <= wdata;
    end else if (wr && addr == `SFC_ADDR_MODE) begin
      mode_seen <= wdata[4:0];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence rd_div_s;
    rd && addr == `SFC_ADDR_DIV;
  endsequence
  sequence rd_mode_s;
    rd && addr == `SFC_ADDR_MODE;
  endsequence
  sequence rd_stat_s;
    rd && addr == `SFC_ADDR_STATUS;
  endsequence
  reset_out_a: assert property (disable iff (1'b0)
    rst |-> rxd_out && !cts_out && dsr_out && rdata == 16'h0000)
    else $error("outputs wrong in reset");
  dsr_on_a: assert property (dsr_out)
    else $error("dsr dropped");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside read slot");
  div_read_a: assert property (rd_div_s |=> rdata == div_seen)
    else $error("divisor readback wrong");
  mode_read_a: assert property (rd_mode_s |=> rdata == {11'h000, mode_seen})
    else $error("mode readback wrong");
  ready_fill_a: assert property (rd_stat_s |=> rdata[0] == (rdata[15:8] != 8'h00))
    else $error("ready flag disagrees with fill");
  cts_pulse_a: assert property ($rose(cts_out) |=> cts_out)
    else $error("cts pulse too short");
  bit_hold_a: assert property ($changed(rxd_out) |=> $stable(rxd_out))
    else $error("serial bit shorter than two clocks");
  cts_flow_a: assert property (mode_seen[0] && $past(mode_seen[0]) |-> cts_out)
    else $error("cts not held in flow mode");
endmodule
bind sfc_channel sfc_channel_chk #(.DEPTH(DEPTH), .DIV_W(DIV_W)) i_sfc_channel_chk (
  .clk_sys, .rst, .addr, .wdata, .wr, .rd, .rdata, .txd_in, .rts_in, .dtr_in,
  .rxd_out, .cts_out, .dsr_out);

// *** testbench/sfc_channel_tb.sv ***
`timescale 1ns/1ps
module sfc_channel_tb;
  import sfc_pkg::*;
  typedef struct {
    sfc_word_t mode;
    logic [7:0] tx;
    logic [7:0] rx;
  } sfc_row_t;
  logic clk_sys, rst, wr, rd, txd_in, rts_in, dtr_in, rxd_out, cts_out, dsr_out;
  sfc_addr_t addr;
  sfc_word_t wdata, rdata, v;
  int bad_count = 0;
  int comparisons = 0;
  int i;
  sfc_row_t rows[4] = '{'{16'h0012, 8'hC5, 8'hA7}, '{16'h0006, 8'h3C, 8'h5A},
    '{16'h0008, 8'h7F, 8'h41}, '{16'h0010, 8'h55, 8'hAA}};
  sfc_channel i_sfc_channel (.clk_sys, .rst, .addr, .wdata,
    .wr, .rd, .rdata, .txd_in, .rts_in, .dtr_in, .rxd_out, .cts_out, .dsr_out);
  sfc_peer i_sfc_peer (.clk_sys, .rxd_out, .cts_out, .dsr_out, .txd_in, .rts_in, .dtr_in);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input sfc_word_t seen, input sfc_word_t exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input sfc_addr_t a, input sfc_word_t d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd_reg(input sfc_addr_t a, output sfc_word_t d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(posedge clk_sys);
    d = rdata;
  endtask
  task automatic set_mode(input sfc_word_t m);
    wr_reg(4'h8, m);
    i_sfc_peer.flow = m[0];
    i_sfc_peer.nb = m[1] ? 8 : 7;
    i_sfc_peer.par = m[3:2];
    i_sfc_peer.stop2 = m[4];
  endtask
  task automatic peer_gets(input logic [7:0] e);
    int j;
    for (j = 0; j < 2000 && i_sfc_peer.got.size() == 0; j++) @(posedge clk_sys);
    v = {8'h00, (i_sfc_peer.got.size() != 0) ? i_sfc_peer.got.pop_front() : 8'hXX};
    chk(v, {8'h00, e});
  endtask
  task automatic wait_ready();
    sfc_word_t s;
    int j;
    s = 16'h0000;
    for (j = 0; j < 200 && s[0] !== 1'b1; j++) rd_reg(4'h4, s);
  endtask
  task report_and_stop();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd_reg(4'h8, v);
    chk(v, 16'h0012);
    rd_reg(4'hC, v);
    chk(v, 16'h0412);
    rd_reg(4'h2, v);
    chk(v, 16'h0000);
    wr_reg(4'hC, 16'h0001);
    rd_reg(4'hC, v);
    chk(v, 16'h0412);
    wr_reg(4'hC, 16'h0004);
    i_sfc_peer.div = 4;
    for (i = 0; i < 4; i++) begin
      set_mode(rows[i].mode);
      wr_reg(4'h0, {8'h00, rows[i].tx});
      repeat (40) @(posedge clk_sys);
      chk(i_sfc_peer.got.size(), 0);
      i_sfc_peer.pulse_rts();
      peer_gets(rows[i].tx & 8'h7F);
      i_sfc_peer.send(rows[i].rx);
      wait_ready();
      chk(cts_out, 1'b0);
      rd_reg(4'h0, v);
      chk(v, {8'h00, rows[i].rx & 8'h7F});
    end
    set_mode(16'h0012);
    i_sfc_peer.dtr_in <= 1'b0;
    repeat (3) @(posedge clk_sys);
    wr_reg(4'h0, 16'h005A);
    rd_reg(4'h4, v);
    chk(v & 16'h0010, 16'h0010);
    i_sfc_peer.dtr_in <= 1'b1;
    wr_reg(4'h4, 16'h0010);
    rd_reg(4'h4, v);
    chk(v & 16'h0010, 16'h0000);
    i_sfc_peer.pulse_rts();
    peer_gets(8'h5A);
    // wrong parity, second char unread: overrun
    set_mode(16'h0006);
    i_sfc_peer.par = 2'h2;
    i_sfc_peer.flow = 1'b1;
    i_sfc_peer.send(8'h5A);
    i_sfc_peer.send(8'h62);
    repeat (6) @(posedge clk_sys);
    rd_reg(4'h4, v);
    chk(v & 16'h00F1, 16'h00A1);
    rd_reg(4'h0, v);
    chk(v, 16'h005A);
    wr_reg(4'h4, 16'h00F0);
    rd_reg(4'h4, v);
    chk(v & 16'h00F0, 16'h0000);
    set_mode(16'h0013);
    i_sfc_peer.send(8'h13);
    repeat (4) @(posedge clk_sys);
    rd_reg(4'h4, v);
    chk(v & 16'h0005, 16'h0004);
    wr_reg(4'h0, 16'h0031);
    repeat (100) @(posedge clk_sys);
    chk(i_sfc_peer.got.size(), 0);
    i_sfc_peer.send(8'h11);
    peer_gets(8'h31);
    for (i = 0; i < 48; i++) begin
      if (i == 47) chk(i_sfc_peer.got.size(), 0);
      i_sfc_peer.send(8'h20 + i[7:0]);
    end
    peer_gets(8'h13);
    i_sfc_peer.send(8'h50);
    i_sfc_peer.send(8'h51);
    repeat (4) @(posedge clk_sys);
    rd_reg(4'h4, v);
    chk(v & 16'hFF0D, 16'h3209);
    for (i = 0; i < 50; i++) begin
      if (i == 16) chk(i_sfc_peer.got.size(), 0);
      if (i == 17) peer_gets(8'h11);
      rd_reg(4'h0, v);
      chk(v, 16'h0020 + i[15:0]);
    end
    chk(i_sfc_peer.errs, 0);
    // second reset in mid-run
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd_reg(4'h8, v);
    chk(v, 16'h0012);
    rd_reg(4'hC, v);
    chk(v, 16'h0412);
    chk(cts_out, 1'b1);
    rd_reg(4'h4, v);
    chk(v, 16'h0000);
    report_and_stop();
  end
endmodule

// *** testbench/sfc_peer.sv ***
`timescale 1ns/1ps
module sfc_peer (
  input wire logic clk_sys,
  input wire logic rxd_out,
  input wire logic cts_out,
  input wire logic dsr_out,
  output logic txd_in,
  output logic rts_in,
  output logic dtr_in
);
  int div = 1042;
  int nb = 8;
  logic [1:0] par = 2'h0;
  logic stop2 = 1'b1;
  logic flow = 1'b0;
  logic cts_seen = 1'b0;
  logic cts_clr = 1'b0;
  int errs = 0;
  logic [7:0] got[$];
  logic [7:0] rx_d;
  int rx_k;
  initial begin
    txd_in = 1'b1;
    rts_in = 1'b0;
    dtr_in = 1'b1;
  end
  always @(posedge clk_sys) cts_seen <= (cts_seen | cts_out) & !cts_clr;
  task automatic bit_out(input logic b);
    txd_in <= b;
    repeat (div) @(posedge clk_sys);
  endtask
  task automatic pulse_rts();
    rts_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rts_in <= 1'b0;
  endtask
  task automatic send(input logic [7:0] ch);
    logic p;
    int i;
    p = 1'b0;
    for (i = 0; i < nb; i++) p ^= ch[i];
    if (dsr_out !== 1'b1) errs++;
    for (i = 0; i < 5000 && !flow && !cts_seen; i++) @(posedge clk_sys);
    if (!flow && !cts_seen) errs++;
    txd_in <= 1'b0;
    cts_clr <= 1'b1;
    @(posedge clk_sys);
    cts_clr <= 1'b0;
    repeat (div - 1) @(posedge clk_sys);
    for (i = 0; i < nb; i++) bit_out(ch[i]);
    if (par == 2'h1 || par == 2'h2) bit_out(p ^ par[1]);
    bit_out(1'b1);
    if (stop2) bit_out(1'b1);
  endtask
  // frame decoder, samples mid bit
  initial forever begin
    @(negedge rxd_out);
    repeat (div / 2) @(posedge clk_sys);
    rx_d = 8'h00;
    for (rx_k = 0; rx_k < nb; rx_k++) begin
      repeat (div) @(posedge clk_sys);
      rx_d[rx_k] = rxd_out;
    end
    repeat (div * ((par == 2'h1 || par == 2'h2) ? 2 : 1)) @(posedge clk_sys);
    if (rxd_out !== 1'b1) errs++;
    got.push_back(rx_d);
  end
endmodule

// *** verilog/sfc_channel.sv ***
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "sfc_map.svh"
module sfc_channel #(
  parameter int DEPTH = `SFC_DEPTH,
  parameter int DIV_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire sfc_pkg::sfc_addr_t addr,
  input wire sfc_pkg::sfc_word_t wdata,
  input wire logic wr,
  input wire logic rd,
  output sfc_pkg::sfc_word_t rdata,
  input wire logic txd_in,
  input wire logic rts_in,
  input wire logic dtr_in,
  output logic rxd_out,
  output logic cts_out,
  output logic dsr_out
);
  import sfc_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);
  localparam logic [CW-1:0] FILL_HI = CW'(DEPTH * `SFC_STOP_PCT / 100);
  localparam logic [CW-1:0] FILL_LO = CW'(DEPTH * `SFC_GO_PCT / 100);
  localparam logic [CW-1:0] FILL_MAX = CW'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  if (DEPTH < 4 || DEPTH > 255 || DIV_W < 4 || DIV_W > 16) begin : g_bad_param
    $error("sfc_channel: unsupported DEPTH or DIV_W");
  end

  // ****************
  // input synchronisers
  // ****************
  logic [1:0] txd_q;
  logic [1:0] rts_q;
  logic [1:0] dtr_q;
  logic txd_s;
  logic rts_s;
  logic dtr_s;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txd_q <= 2'h3;
      rts_q <= 2'h0;
      dtr_q <= 2'h0;
    end else begin
      txd_q <= {txd_q[0], txd_in};
      rts_q <= {rts_q[0], rts_in};
      dtr_q <= {dtr_q[0], dtr_in};
    end
  end
  assign txd_s = txd_q[1];
  assign rts_s = rts_q[1];
  assign dtr_s = dtr_q[1];

  // ****************
  // configuration registers
  // ****************
  logic [4:0] mode_set;
  logic [DIV_W-1:0] divisor;
  logic flow_mode;
  logic len8;
  logic par_en;
  logic par_odd;
  logic stop2;
  logic wr_data;
  logic wr_status;
  logic rd_data;

  assign wr_data = wr && addr == `SFC_ADDR_DATA;
  assign wr_status = wr && addr == `SFC_ADDR_STATUS;
  assign rd_data = rd && addr == `SFC_ADDR_DATA;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_set <= `SFC_MODE_RESET;
      divisor <= DIV_W'(`SFC_DIV_RESET);
    end else if (wr && addr == `SFC_ADDR_MODE) begin
      mode_set <= wdata[4:0];
    end else if (wr && addr == `SFC_ADDR_DIV && wdata[DIV_W-1:1] != '0) begin
      divisor <= wdata[DIV_W-1:0];
    end
  end

  assign flow_mode = mode_set[`SFC_MODE_FLOW];
  assign len8 = mode_set[`SFC_MODE_LEN8];
  assign par_en = mode_set[`SFC_MODE_PAR_HI:`SFC_MODE_PAR_LO] == SFC_PAR_EVEN ||
                  mode_set[`SFC_MODE_PAR_HI:`SFC_MODE_PAR_LO] == SFC_PAR_ODD;
  assign par_odd = mode_set[`SFC_MODE_PAR_HI:`SFC_MODE_PAR_LO] == SFC_PAR_ODD;
  assign stop2 = mode_set[`SFC_MODE_STOP2];

  // ****************
  // receive buffer
  // ****************
  logic [7:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] fill;
  logic push;
  logic pop;
  logic [7:0] rx_char;
  logic receive_ready_flag;

  // ready while buffer holds a character
  assign receive_ready_flag = fill != '0;
  assign pop = rd_data && receive_ready_flag;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= rx_char;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr == PTR_LAST ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr == PTR_LAST ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        fill <= fill + 1'b1;
      end else if (pop && !push) begin
        fill <= fill - 1'b1;
      end
    end
  end

  // ****************
  // receiver
  // ****************
  sfc_rx_state_t rx_state;
  logic [DIV_W-1:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [8:0] rx_sh;
  logic [3:0] rx_need;
  logic rx_done;
  logic rx_par_bad;
  logic rx_frm_bad;
  logic [7:0] rx_mask;

  assign rx_need = (len8 ? 4'h8 : 4'h7) + {3'h0, par_en};
  assign rx_mask = len8 ? 8'hFF : 8'h7F;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_state <= SFC_RX_IDLE;
      rx_cnt <= '0;
      rx_bit <= 4'h0;
      rx_sh <= 9'h000;
      rx_done <= 1'b0;
      rx_frm_bad <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_state)
        SFC_RX_IDLE: begin
          if (!txd_s) begin
            rx_state <= SFC_RX_START;
            rx_cnt <= divisor >> 1;
          end
        end
        SFC_RX_START: begin
          if (rx_cnt != '0) begin
            rx_cnt <= rx_cnt - 1'b1;
          end else if (txd_s) begin
            rx_state <= SFC_RX_IDLE;
          end else begin
            rx_state <= SFC_RX_BITS;
            rx_cnt <= divisor - 1'b1;
            rx_bit <= 4'h0;
            rx_sh <= 9'h000;
          end
        end
        SFC_RX_BITS: begin
          if (rx_cnt != '0) begin
            rx_cnt <= rx_cnt - 1'b1;
          end else if (rx_bit < rx_need) begin
            rx_sh[rx_bit] <= txd_s;
            rx_bit <= rx_bit + 1'b1;
            rx_cnt <= divisor - 1'b1;
          end else begin
            rx_done <= 1'b1;
            rx_frm_bad <= !txd_s;
            rx_state <= SFC_RX_IDLE;
          end
        end
        default: begin
          rx_state <= SFC_RX_IDLE;
        end
      endcase
    end
  end

  assign rx_char = {1'b0, rx_sh[6:0]};
  assign rx_par_bad = par_en &&
                      ((^(rx_sh[7:0] & rx_mask)) ^ (len8 ? rx_sh[8] : rx_sh[7]) ^ par_odd);

  logic is_xoff;
  logic is_xon;
  logic rx_full;
  assign is_xoff = flow_mode && rx_char == `SFC_CHAR_XOFF;
  assign is_xon = flow_mode && rx_char == `SFC_CHAR_XON;
  // hardware mode holds one character only
  assign rx_full = flow_mode ? fill == FILL_MAX : receive_ready_flag;
  assign push = rx_done && !is_xoff && !is_xon && !rx_full;

  // ****************
  // peer flow state
  // ****************
  logic suspended;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      suspended <= 1'b0;
    end else if (!flow_mode) begin
      suspended <= 1'b0;
    end else if (rx_done && is_xoff) begin
      suspended <= 1'b1;
    end else if (rx_done && is_xon) begin
      suspended <= 1'b0;
    end
  end

  // ****************
  // transmitter
  // ****************
  sfc_tx_state_t tx_state;
  logic [7:0] tx_hold;
  logic hold_full;
  logic rts_seen;
  logic xoff_sent;
  logic want_xoff;
  logic want_xon;
  logic send_ctl;
  logic send_user;
  logic tx_go;
  logic [11:0] tx_sh;
  logic [3:0] tx_left;
  logic [DIV_W-1:0] tx_cnt;
  logic [3:0] tx_nbits;
  logic dtr_err_set;

  function automatic logic [11:0] sfc_frame(input logic [7:0] ch, input logic l8,
                                            input logic pe, input logic po);
    logic [11:0] f;
    logic [7:0] d;
    int n;
    f = 12'hFFF;
    d = {1'b0, ch[6:0]};
    n = 1;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || l8) begin
        f[n] = d[i];
        n = n + 1;
      end
    end
    if (pe) begin
      f[n] = (^d) ^ po;
    end
    return f;
  endfunction

  assign tx_nbits = (len8 ? 4'h9 : 4'h8) + {3'h0, par_en} + (stop2 ? 4'h2 : 4'h1);
  assign want_xoff = flow_mode && !xoff_sent && fill >= FILL_HI;
  assign want_xon = flow_mode && xoff_sent && fill <= FILL_LO;
  assign tx_go = flow_mode ? !suspended : (dtr_s && rts_seen);
  assign send_ctl = tx_state == SFC_TX_IDLE && (want_xoff || want_xon);
  assign send_user = tx_state == SFC_TX_IDLE && !send_ctl && hold_full && tx_go;
  assign dtr_err_set = wr_data && !hold_full && !flow_mode && !dtr_s;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_hold <= 8'h00;
      hold_full <= 1'b0;
      rts_seen <= 1'b0;
    end else begin
      if (send_user) begin
        hold_full <= 1'b0;
        rts_seen <= 1'b0;
      end else if (wr_data && !hold_full) begin
        tx_hold <= wdata[7:0];
        hold_full <= 1'b1;
      end else if (hold_full && rts_s) begin
        rts_seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xoff_sent <= 1'b0;
    end else if (!flow_mode) begin
      xoff_sent <= 1'b0;
    end else if (send_ctl) begin
      xoff_sent <= want_xoff;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_state <= SFC_TX_IDLE;
      tx_sh <= 12'hFFF;
      tx_left <= 4'h0;
      tx_cnt <= '0;
      rxd_out <= 1'b1;
    end else begin
      case (tx_state)
        SFC_TX_IDLE: begin
          rxd_out <= 1'b1;
          if (send_ctl || send_user) begin
            tx_sh <= sfc_frame(send_ctl ? (want_xoff ? `SFC_CHAR_XOFF : `SFC_CHAR_XON) :
                               tx_hold, len8, par_en, par_odd);
            tx_left <= tx_nbits;
            tx_cnt <= '0;
            tx_state <= SFC_TX_SHIFT;
          end
        end
        SFC_TX_SHIFT: begin
          if (tx_cnt != '0) begin
            tx_cnt <= tx_cnt - 1'b1;
          end else if (tx_left == 4'h0) begin
            rxd_out <= 1'b1;
            tx_state <= SFC_TX_IDLE;
          end else begin
            rxd_out <= tx_sh[0];
            tx_sh <= {1'b1, tx_sh[11:1]};
            tx_left <= tx_left - 1'b1;
            tx_cnt <= divisor - 1'b1;
          end
        end
        default: begin
          tx_state <= SFC_TX_IDLE;
        end
      endcase
    end
  end

  // ****************
  // handshake outputs
  // ****************
  logic cts_done;
  logic [DIV_W-1:0] cts_cnt;

  // pulsed CTS, inverse of ready flag, in hardware mode; held high in flow mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cts_out <= 1'b0;
      cts_done <= 1'b0;
      cts_cnt <= '0;
    end else if (flow_mode) begin
      cts_out <= 1'b1;
      cts_done <= 1'b0;
      cts_cnt <= '0;
    end else if (receive_ready_flag || push) begin
      cts_out <= 1'b0;
      cts_done <= 1'b0;
      cts_cnt <= '0;
    end else if (!cts_done) begin
      cts_out <= 1'b1;
      cts_cnt <= cts_cnt + 1'b1;
      // >= so a divisor lowered mid-pulse still ends it
      if (cts_cnt >= divisor - 1'b1) begin
        cts_done <= 1'b1;
        cts_out <= 1'b0;
      end
    end else begin
      cts_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dsr_out <= 1'b1;
    end else begin
      dsr_out <= 1'b1;
    end
  end

  // ****************
  // sticky errors and read port
  // ****************
  logic [3:0] err;
  logic [3:0] err_set;

  assign err_set = {rx_done && rx_full && !is_xoff && !is_xon,
                    rx_done && rx_frm_bad, rx_done && rx_par_bad, dtr_err_set};

  // errors: set wins over write-one clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err <= 4'h0;
    end else begin
      err <= (err & ~(wr_status ? wdata[7:4] : 4'h0)) | err_set;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `SFC_ADDR_DATA: rdata <= receive_ready_flag ? {8'h00, mem[rd_ptr]} : 16'h0000;
        `SFC_ADDR_STATUS: rdata <= {8'(fill), err, xoff_sent, suspended,
                                    hold_full || tx_state != SFC_TX_IDLE,
                                    receive_ready_flag};
        `SFC_ADDR_MODE: rdata <= {11'h000, mode_set};
        `SFC_ADDR_DIV: rdata <= 16'(divisor);
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule

// *** verilog/sfc_map.svh ***
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH
// Function
// - CTS line is inverse of receive-ready flag (code holds CTS high in flow mode)
// - ready flag sets on arrival, clears on read
// - hardware mode sends only with RTS and DTR
// - DSR output held active in hardware mode
// - CTS inactive until able to accept character
// - DTR off at load reports an error
// - held character waits for RTS pulse
// - CTS enable given as a pulse (code holds CTS high in flow mode)
// - flow mode: Ctrl-S from peer suspends sending
// - overrun after Ctrl-S tolerated by peer
// - Ctrl-Q from peer resumes suspended sending
// - flow mode stores received characters in 96-byte buffer
// - half-full buffer sends Ctrl-S to peer
// - characters after stop request still stored
// - fill down to 35 percent sends Ctrl-Q
// - seven or eight data bits selectable
// - eight-bit mode: MSB sent and read as 0
// - even, odd or no parity selectable
// - one or two stop bits selectable
// - setting selects hardware or flow control mode
// - reset: 9600 baud, hardware, 8N2

// ****************
// register offsets
// ****************
`define SFC_ADDR_DATA 4'h0
`define SFC_ADDR_STATUS 4'h4
`define SFC_ADDR_MODE 4'h8
`define SFC_ADDR_DIV 4'hC

// ****************
// mode_set fields
// ****************
`define SFC_MODE_FLOW 0
`define SFC_MODE_LEN8 1
`define SFC_MODE_PAR_LO 2
`define SFC_MODE_PAR_HI 3
`define SFC_MODE_STOP2 4
`define SFC_MODE_RESET 5'h12

// ****************
// status fields
// ****************
`define SFC_ST_READY 0
`define SFC_ST_HOLD 1
`define SFC_ST_SUSP 2
`define SFC_ST_XOFF 3
`define SFC_ST_DTR_ERR 4
`define SFC_ST_PAR_ERR 5
`define SFC_ST_FRM_ERR 6
`define SFC_ST_OVR_ERR 7

// ****************
// timing and flow
// ****************
`define SFC_CLK_HZ 10000000
`define SFC_BAUD_RESET 9600
`define SFC_DIV_RESET ((`SFC_CLK_HZ + `SFC_BAUD_RESET / 2) / `SFC_BAUD_RESET)
`define SFC_DEPTH 96
`define SFC_STOP_PCT 50
`define SFC_GO_PCT 35
`define SFC_CHAR_XOFF 8'h13
`define SFC_CHAR_XON 8'h11
`endif

// *** verilog/sfc_pkg.sv ***
package sfc_pkg;
  typedef enum logic [1:0] {
    SFC_PAR_NONE = 2'h0,
    SFC_PAR_EVEN = 2'h1,
    SFC_PAR_ODD = 2'h2
  } sfc_par_t;
  typedef enum logic [1:0] {
    SFC_TX_IDLE = 2'b01,
    SFC_TX_SHIFT = 2'b10
  } sfc_tx_state_t;
  typedef enum logic [2:0] {
    SFC_RX_IDLE = 3'b001,
    SFC_RX_START = 3'b010,
    SFC_RX_BITS = 3'b100
  } sfc_rx_state_t;
  typedef logic [3:0] sfc_addr_t;
  typedef logic [15:0] sfc_word_t;
endpackage
